// ==== src/spg_top.sv ====
// Six-channel step pulse generator with Wishbone registers and power enable
//
// Local design decisions: the register addresses and the Wishbone slave port.
`include "spg_defs.svh"
module spg_top import spg_pkg::*; #(
  parameter int unsigned ACC_TICK_CYC = 32'(`SPG_ACC_TICK_CYC)
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [8:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_power_fault,
  output logic [5:0] o_step_first,
  output logic [5:0] o_step_second,
  output logic o_power_en
);

  localparam int NCH = `SPG_NUM_CH;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge

  // Nanoseconds to clock cycles, rounded up, at least one cycle
  function automatic logic [31:0] ns_to_cyc(input logic [31:0] ns);
    logic [32:0] c;
    c = ({1'b0, ns} + `SPG_CLK_PERIOD_NS - 33'h000000001) / `SPG_CLK_PERIOD_NS;
    if (c == 33'h000000000) begin
      c = 33'h000000001;
    end
    return c[31:0];
  endfunction : ns_to_cyc

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [5:0] ctrl_q [NCH];
  logic [31:0] pos_cmd_q [NCH];
  logic [31:0] vel_cmd_q [NCH];
  logic [31:0] maxvel_q [NCH];
  logic [31:0] maxacc_q [NCH];
  logic [15:0] scale_q [NCH];
  logic [31:0] steplen_q [NCH];
  logic [31:0] stepspace_q [NCH];
  logic [31:0] dirdelay_q [NCH];
  logic [31:0] count_w [NCH];
  logic [NCH-1:0] ready_w;

  logic pwr_req_q;
  logic wd_en_q;
  logic [31:0] wd_timeout_q;
  logic [31:0] wd_cnt_q;
  logic wd_expired_q;
  logic fault_m1_q;
  logic fault_m2_q;
  logic fault_m3_q;
  logic fault_q;

  logic access;
  logic wr;
  logic [2:0] slot;
  logic [3:0] idx;
  logic kick;
  logic [31:0] rd_d;

  assign access = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  assign slot = i_wb_adr[8:6];
  assign idx = i_wb_adr[5:2];
  assign kick = wr && (slot == `SPG_GLB_SLOT) && (idx == `SPG_REG_WD_KICK);

  ////////////////////////////////////////////////////////////////////////////////
  // Channel register writes

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c] <= `SPG_RST_CTRL;
        pos_cmd_q[c] <= 32'h00000000;
        vel_cmd_q[c] <= 32'h00000000;
        maxvel_q[c] <= 32'h00000000;
        maxacc_q[c] <= 32'h00000000;
        scale_q[c] <= `SPG_RST_SCALE;
        steplen_q[c] <= `SPG_RST_STEPLEN;
        stepspace_q[c] <= `SPG_RST_STEPSPACE;
        dirdelay_q[c] <= `SPG_RST_DIRDELAY;
      end
    end else if (wr) begin
      for (int c = 0; c < NCH; c++) begin
        if (slot == 3'(c)) begin
          case (idx)
            `SPG_REG_CTRL: ctrl_q[c] <= 6'(wmerge({26'h0, ctrl_q[c]}, i_wb_dat, i_wb_sel));
            `SPG_REG_POS_CMD: pos_cmd_q[c] <= wmerge(pos_cmd_q[c], i_wb_dat, i_wb_sel);
            `SPG_REG_VEL_CMD: vel_cmd_q[c] <= wmerge(vel_cmd_q[c], i_wb_dat, i_wb_sel);
            `SPG_REG_MAXVEL: maxvel_q[c] <= wmerge(maxvel_q[c], i_wb_dat, i_wb_sel);
            `SPG_REG_MAXACC: maxacc_q[c] <= wmerge(maxacc_q[c], i_wb_dat, i_wb_sel);
            `SPG_REG_SCALE: scale_q[c] <= 16'(wmerge({16'h0, scale_q[c]}, i_wb_dat, i_wb_sel));
            `SPG_REG_STEPLEN: steplen_q[c] <= wmerge(steplen_q[c], i_wb_dat, i_wb_sel);
            `SPG_REG_STEPSPACE: stepspace_q[c] <= wmerge(stepspace_q[c], i_wb_dat, i_wb_sel);
            `SPG_REG_DIRDELAY: dirdelay_q[c] <= wmerge(dirdelay_q[c], i_wb_dat, i_wb_sel);
            default: ;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Global registers, watchdog, fault input and power enable

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pwr_req_q <= 1'b0;
      wd_en_q <= 1'b0;
      wd_timeout_q <= `SPG_RST_WD_TIMEOUT;
    end else if (wr && slot == `SPG_GLB_SLOT) begin
      if (idx == `SPG_REG_PWR_CTRL && i_wb_sel[0]) begin
        pwr_req_q <= i_wb_dat[`SPG_PWR_REQ_BIT];
        wd_en_q <= i_wb_dat[`SPG_WD_EN_BIT];
      end
      if (idx == `SPG_REG_WD_TIMEOUT) begin
        wd_timeout_q <= wmerge(wd_timeout_q, i_wb_dat, i_wb_sel);
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !wd_en_q || kick) begin
      wd_cnt_q <= 32'h00000000;
    end else if (wd_cnt_q < wd_timeout_q) begin
      wd_cnt_q <= wd_cnt_q + 32'h00000001;
    end
  end

  // Expiry is sticky; a kick in the same cycle does not hide it
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || !wd_en_q) begin
      wd_expired_q <= 1'b0;
    end else if (wd_cnt_q >= wd_timeout_q && !wd_expired_q) begin
      wd_expired_q <= 1'b1;
    end else if (kick) begin
      wd_expired_q <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      fault_m1_q <= 1'b0;
      fault_m2_q <= 1'b0;
      fault_m3_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      fault_m1_q <= i_power_fault;
      fault_m2_q <= fault_m1_q;
      fault_m3_q <= fault_m2_q;
      if (fault_m2_q == fault_m3_q) begin
        fault_q <= fault_m3_q;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_power_en <= 1'b0;
    end else begin
      o_power_en <= pwr_req_q && !wd_expired_q && !fault_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Acceleration tick

  logic [31:0] tick_cnt_q;
  logic tick_q;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= 32'(ACC_TICK_CYC - 1)) begin
      tick_cnt_q <= 32'h00000000;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h00000001;
      tick_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel rate generation

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic signed [48:0] pos_prod;
    logic signed [48:0] vel_prod;
    logic [47:0] vlim_prod;
    logic [47:0] alim_prod;
    logic signed [31:0] err;
    logic signed [31:0] vdes;
    logic signed [31:0] vclamp;
    logic signed [31:0] vlim;
    logic signed [31:0] dv;
    logic signed [31:0] cur_v_q;
    logic [31:0] abs_v;
    logic [32:0] acc_q;
    logic run;
    logic req;
    logic take;

    always_comb begin
      pos_prod = $signed(pos_cmd_q[g]) * $signed({1'b0, scale_q[g]});
      vel_prod = $signed(vel_cmd_q[g]) * $signed({1'b0, scale_q[g]});
      vlim_prod = maxvel_q[g] * scale_q[g];
      alim_prod = maxacc_q[g] * scale_q[g];
      vlim = $signed({1'b0, vlim_prod[46:16]});
      dv = $signed({10'h000, alim_prod[47:26]});
      if (dv == 32'sh00000000) begin
        dv = 32'sh00000001;
      end
      err = pos_prod[47:16] - $signed(count_w[g]);
      if (ctrl_q[g][`SPG_CTRL_LOOP_BIT]) begin
        vdes = vel_prod[47:16];
      end else begin
        vdes = err <<< `SPG_POS_GAIN_SHIFT;
      end
      vclamp = vdes;
      if (maxvel_q[g] != 32'h00000000) begin
        if (vdes > vlim) begin
          vclamp = vlim;
        end else if (vdes < -vlim) begin
          vclamp = -vlim;
        end
      end
      abs_v = cur_v_q[31] ? 32'(-cur_v_q) : 32'(cur_v_q);
      run = ctrl_q[g][`SPG_CTRL_RUN_BIT];
      req = run && (acc_q >= `SPG_CLK_HZ) && (cur_v_q != 32'sh00000000);
      take = req && ready_w[g];
    end

    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || !run) begin
        cur_v_q <= 32'sh00000000;
      end else if (maxacc_q[g] == 32'h00000000) begin
        cur_v_q <= vclamp;
      end else if (tick_q) begin
        if (vclamp > cur_v_q + dv) begin
          cur_v_q <= cur_v_q + dv;
        end else if (vclamp < cur_v_q - dv) begin
          cur_v_q <= cur_v_q - dv;
        end else begin
          cur_v_q <= vclamp;
        end
      end
    end

    // Phase accumulator: one step each time it passes the clock rate
    always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || !run) begin
        acc_q <= 33'h000000000;
      end else if (take) begin
        acc_q <= acc_q - `SPG_CLK_HZ;
      end else if (acc_q < `SPG_CLK_HZ) begin
        acc_q <= acc_q + {1'b0, abs_v};
      end
    end

    spg_channel u_channel (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_run(run),
      .i_fmt(ctrl_q[g][`SPG_CTRL_FMT_LSB +: 2]),
      .i_first_output_polarity(ctrl_q[g][`SPG_CTRL_INV1_BIT]),
      .i_second_output_polarity(ctrl_q[g][`SPG_CTRL_INV2_BIT]),
      .i_len_cyc(ns_to_cyc(steplen_q[g])),
      .i_space_cyc(ns_to_cyc(stepspace_q[g])),
      .i_dir_cyc(ns_to_cyc(dirdelay_q[g])),
      .i_step_req(take),
      .i_step_neg(cur_v_q[31]),
      .o_ready(ready_w[g]),
      .o_out_first(o_step_first[g]),
      .o_out_second(o_step_second[g]),
      .o_count(count_w[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and bus answer

  logic signed [47:0] fb_num;
  logic signed [47:0] fb_quo;
  logic [31:0] emitted_step_total;
  logic [15:0] sel_scale;

  always_comb begin
    rd_d = 32'h00000000;
    emitted_step_total = 32'h00000000;
    sel_scale = 16'h0000;
    for (int c = 0; c < NCH; c++) begin
      if (slot == 3'(c)) begin
        emitted_step_total = count_w[c];
        sel_scale = scale_q[c];
      end
    end
    fb_num = $signed({emitted_step_total, 16'h0000});
    fb_quo = (sel_scale == 16'h0000) ? 48'sh000000000000 :
             fb_num / $signed({32'h00000000, sel_scale});
    for (int c = 0; c < NCH; c++) begin
      if (slot == 3'(c)) begin
        case (idx)
          `SPG_REG_CTRL: rd_d = {26'h0000000, ctrl_q[c]};
          `SPG_REG_POS_CMD: rd_d = pos_cmd_q[c];
          `SPG_REG_VEL_CMD: rd_d = vel_cmd_q[c];
          `SPG_REG_MAXVEL: rd_d = maxvel_q[c];
          `SPG_REG_MAXACC: rd_d = maxacc_q[c];
          `SPG_REG_SCALE: rd_d = {16'h0000, scale_q[c]};
          `SPG_REG_STEPLEN: rd_d = steplen_q[c];
          `SPG_REG_STEPSPACE: rd_d = stepspace_q[c];
          `SPG_REG_DIRDELAY: rd_d = dirdelay_q[c];
          `SPG_REG_COUNT: rd_d = emitted_step_total;
          `SPG_REG_POSFB: rd_d = fb_quo[31:0];
          default: rd_d = 32'h00000000;
        endcase
      end
    end
    if (slot == `SPG_GLB_SLOT) begin
      case (idx)
        `SPG_REG_PWR_CTRL: rd_d = {30'h00000000, wd_en_q, pwr_req_q};
        `SPG_REG_WD_TIMEOUT: rd_d = wd_timeout_q;
        `SPG_REG_STATUS: rd_d = {29'h00000000, o_power_en, wd_expired_q, fault_q};
        default: rd_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= access;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_wb_dat <= 32'h00000000;
    end else if (access) begin
      o_wb_dat <= rd_d;
    end
  end

endmodule : spg_top

// ==== src/spg_defs.svh ====
// Constants of the six-channel step pulse generator: offsets, fields, resets, timing
`ifndef SPG_DEFS_SVH
`define SPG_DEFS_SVH

`define SPG_NUM_CH 6
`define SPG_CLK_HZ 33'h00BEBC200
`define SPG_CLK_PERIOD_NS 33'h000000005
`define SPG_ACC_TICK_HZ 33'h000000400
`define SPG_ACC_TICK_CYC (`SPG_CLK_HZ / `SPG_ACC_TICK_HZ)
`define SPG_POS_GAIN_SHIFT 10

// Channel blocks: slot = adr[8:6], word index = adr[5:2]
`define SPG_GLB_SLOT 3'h6
`define SPG_REG_CTRL 4'h0
`define SPG_REG_POS_CMD 4'h1
`define SPG_REG_VEL_CMD 4'h2
`define SPG_REG_MAXVEL 4'h3
`define SPG_REG_MAXACC 4'h4
`define SPG_REG_SCALE 4'h5
`define SPG_REG_STEPLEN 4'h6
`define SPG_REG_STEPSPACE 4'h7
`define SPG_REG_DIRDELAY 4'h8
`define SPG_REG_COUNT 4'h9
`define SPG_REG_POSFB 4'hA
`define SPG_REG_PWR_CTRL 4'h0
`define SPG_REG_WD_TIMEOUT 4'h1
`define SPG_REG_STATUS 4'h2
`define SPG_REG_WD_KICK 4'h3

`define SPG_CTRL_FMT_LSB 0
`define SPG_CTRL_LOOP_BIT 2
`define SPG_CTRL_INV1_BIT 3
`define SPG_CTRL_INV2_BIT 4
`define SPG_CTRL_RUN_BIT 5
`define SPG_PWR_REQ_BIT 0
`define SPG_WD_EN_BIT 1
`define SPG_STAT_FAULT_BIT 0
`define SPG_STAT_WD_EXP_BIT 1
`define SPG_STAT_PWR_BIT 2

`define SPG_RST_CTRL 6'h00
`define SPG_RST_SCALE 16'h0001
`define SPG_RST_STEPLEN 32'h000003E8
`define SPG_RST_STEPSPACE 32'h000003E8
`define SPG_RST_DIRDELAY 32'h000007D0
`define SPG_RST_WD_TIMEOUT 32'h000F4240

`endif

// ==== src/spg_pkg.sv ====
// Types shared by the step pulse generator modules
package spg_pkg;

  typedef enum logic [1:0] {
    SPG_FMT_STEP_DIR,
    SPG_FMT_UP_DOWN,
    SPG_FMT_QUAD
  } spg_fmt_t;

  typedef enum logic [2:0] {
    SPG_ST_IDLE,
    SPG_ST_DIR_WAIT,
    SPG_ST_DIR_SETUP,
    SPG_ST_PULSE,
    SPG_ST_SPACE
  } spg_state_t;

endpackage : spg_pkg

// ==== src/spg_channel.sv ====
// One pulse channel: step timing, direction timing, output format, step count
`include "spg_defs.svh"
module spg_channel import spg_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [1:0] i_fmt,
  input wire logic i_first_output_polarity,
  input wire logic i_second_output_polarity,
  input wire logic [31:0] i_len_cyc,
  input wire logic [31:0] i_space_cyc,
  input wire logic [31:0] i_dir_cyc,
  input wire logic i_step_req,
  input wire logic i_step_neg,
  output logic o_ready,
  output logic o_out_first,
  output logic o_out_second,
  output logic [31:0] o_count
);

  spg_state_t state_q;
  logic [31:0] tmr_q;
  logic [31:0] since_q;
  logic pend_neg_q;
  logic dir_neg_q;
  logic pulse_q;
  logic [1:0] quad_q;
  logic start;
  logic dir_commit;
  logic end_pulse;
  logic raw_first;
  logic raw_second;
  logic [1:0] gray;

  assign o_ready = (state_q == SPG_ST_IDLE) && i_run;

  always_comb begin
    start = 1'b0;
    dir_commit = 1'b0;
    end_pulse = 1'b0;
    case (state_q)
      SPG_ST_IDLE: start = i_step_req && (i_step_neg == dir_neg_q);
      SPG_ST_DIR_WAIT: dir_commit = (since_q >= i_dir_cyc);
      SPG_ST_DIR_SETUP: start = (tmr_q >= i_dir_cyc);
      SPG_ST_PULSE: end_pulse = (tmr_q >= i_len_cyc);
      default: start = 1'b0;
    endcase
    start = start && i_run;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_q <= SPG_ST_IDLE;
      tmr_q <= 32'h00000000;
      pend_neg_q <= 1'b0;
    end else if (!i_run) begin
      state_q <= SPG_ST_IDLE;
      tmr_q <= 32'h00000000;
    end else begin
      case (state_q)
        SPG_ST_IDLE: begin
          if (start) begin
            state_q <= SPG_ST_PULSE;
            tmr_q <= 32'h00000001;
          end else if (i_step_req) begin
            pend_neg_q <= i_step_neg;
            state_q <= SPG_ST_DIR_WAIT;
          end
        end
        SPG_ST_DIR_WAIT: begin
          if (dir_commit) begin
            state_q <= SPG_ST_DIR_SETUP;
            tmr_q <= 32'h00000001;
          end
        end
        SPG_ST_DIR_SETUP: begin
          if (start) begin
            state_q <= SPG_ST_PULSE;
            tmr_q <= 32'h00000001;
          end else begin
            tmr_q <= tmr_q + 32'h00000001;
          end
        end
        SPG_ST_PULSE: begin
          if (end_pulse) begin
            state_q <= SPG_ST_SPACE;
            tmr_q <= 32'h00000001;
          end else begin
            tmr_q <= tmr_q + 32'h00000001;
          end
        end
        SPG_ST_SPACE: begin
          if (tmr_q >= i_space_cyc) begin
            state_q <= SPG_ST_IDLE;
          end else begin
            tmr_q <= tmr_q + 32'h00000001;
          end
        end
        default: state_q <= SPG_ST_IDLE;
      endcase
    end
  end

  // Pulse level, dropped at once when the channel stops
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pulse_q <= 1'b0;
    end else if (start) begin
      pulse_q <= 1'b1;
    end else if (end_pulse || !i_run) begin
      pulse_q <= 1'b0;
    end
  end

  // Cycles since the last pulse ended, saturating
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      since_q <= 32'hFFFFFFFF;
    end else if (pulse_q) begin
      since_q <= 32'h00000001;
    end else if (since_q != 32'hFFFFFFFF) begin
      since_q <= since_q + 32'h00000001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dir_neg_q <= 1'b0;
    end else if (dir_commit && i_run) begin
      dir_neg_q <= pend_neg_q;
    end
  end

  // Step count and quadrature phase advance at each pulse start
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_count <= 32'h00000000;
      quad_q <= 2'h0;
    end else if (start) begin
      o_count <= dir_neg_q ? o_count - 32'h00000001 : o_count + 32'h00000001;
      quad_q <= dir_neg_q ? quad_q - 2'h1 : quad_q + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Output format and polarity
  assign gray = {quad_q[1], quad_q[1] ^ quad_q[0]};

  always_comb begin
    case (spg_fmt_t'(i_fmt))
      SPG_FMT_UP_DOWN: begin
        raw_first = pulse_q && !dir_neg_q;
        raw_second = pulse_q && dir_neg_q;
      end
      SPG_FMT_QUAD: begin
        raw_first = gray[0];
        raw_second = gray[1];
      end
      default: begin
        raw_first = pulse_q;
        raw_second = dir_neg_q;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_out_first <= 1'b0;
      o_out_second <= 1'b0;
    end else begin
      o_out_first <= raw_first ^ i_first_output_polarity;
      o_out_second <= raw_second ^ i_second_output_polarity;
    end
  end

endmodule : spg_channel

// ==== dv/spg_asserts.sv ====
// Checker of bus answer, power enable and channel 0 step timing
module spg_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  input wire logic i_power_fault,
  input wire logic [5:0] o_step_first,
  input wire logic [5:0] o_step_second,
  input wire logic o_power_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////
  // Bench sets channel 0 to 4-cycle pulse, space and delay
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_pulse;
    o_step_first[0] [*4] ##1 !o_step_first[0];
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> o_wb_ack)
    else $error("ack late");
  AST_ACK_ONE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack too long");
  AST_STEP_LEN: assert property ($rose(o_step_first[0]) |-> s_pulse)
    else $error("pulse length");
  AST_STEP_SPACE: assert property ($fell(o_step_first[0]) |=> !o_step_first[0] [*3])
    else $error("pulse space");
  AST_DIR_AFTER: assert property ($fell(o_step_first[0]) |=> $stable(o_step_second[0]) [*3])
    else $error("dir after pulse");
  AST_DIR_BEFORE: assert property ($changed(o_step_second[0]) |=> !o_step_first[0] [*3])
    else $error("pulse after dir");
  AST_PWR_FAULT: assert property (i_power_fault [*6] |=> !o_power_en)
    else $error("power on in fault");
  AST_RST_OUT: assert property (disable iff (1'b0)
    !i_rst_n |=> o_step_first == 6'h00 && !o_power_en)
    else $error("outputs in reset");
endmodule : spg_asserts

// ==== dv/spg_drive_model.sv ====
// Drive model: decodes one channel's two lines into a signed step position
module spg_drive_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [1:0] i_fmt,
  input wire logic i_a,
  input wire logic i_b,
  output logic [31:0] o_pos
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_q = 1'b0;
  logic b_q = 1'b0;
  always @(posedge i_clk) begin
    a_q <= i_a;
    b_q <= i_b;
    if (!i_rst_n) begin
      o_pos <= 32'h0;
    end else if (i_fmt == 2'h2) begin
      // Forward walk is 00, 01, 11, 10 on (second, first)
      if ({b_q, a_q} != {i_b, i_a}) begin
        o_pos <= ({b_q, a_q, i_b, i_a} inside {4'h1, 4'h7, 4'hE, 4'h8}) ?
          o_pos + 32'h1 : o_pos - 32'h1;
      end
    end else if (i_fmt == 2'h1) begin
      if (i_a && !a_q) o_pos <= o_pos + 32'h1;
      if (i_b && !b_q) o_pos <= o_pos - 32'h1;
    end else if (i_a && !a_q) begin
      o_pos <= i_b ? o_pos - 32'h1 : o_pos + 32'h1;
    end
  end
endmodule : spg_drive_model

// ==== dv/tb_top.sv ====
// Self-checking bench of the step pulse generator
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] CTRL [6] = '{6'h24, 6'h25, 6'h26, 6'h2C, 6'h34, 6'h04};
  localparam logic [31:0] VN = 32'hB3B4C000;
  localparam logic [31:0] VP = 32'h4C4B4000;
  localparam logic [31:0] VEL [6] = '{VN, VN, VN, VP, VP, VP};
  localparam logic [31:0] MAXV [6] = '{32'h0, 32'h0, 32'h0, 32'h0F424000, 32'h0, 32'h0};
  localparam logic [8:0] RA [9] = '{9'h000, 9'h014, 9'h018, 9'h01C, 9'h020, 9'h024,
    9'h184, 9'h188, 9'h1C0};
  localparam logic [31:0] RV [9] = '{32'h0, 32'h1, 32'h3E8, 32'h3E8, 32'h7D0, 32'h0,
    32'hF4240, 32'h0, 32'h0};
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [8:0] i_wb_adr = 9'h000;
  logic [3:0] i_wb_sel = 4'hF;
  logic [31:0] i_wb_dat = 32'h0;
  logic i_power_fault = 1'b0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic [5:0] o_step_first;
  logic [5:0] o_step_second;
  logic o_power_en;
  logic [31:0] pos [6];
  logic [31:0] q;
  logic [31:0] old;
  int num_errors = 0;
  int cmp_count = 0;
  int cyc_cnt = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  spg_top #(.ACC_TICK_CYC(16)) DUT (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_power_fault(i_power_fault),
    .o_step_first(o_step_first), .o_step_second(o_step_second), .o_power_en(o_power_en));
  for (genvar g = 0; g < 6; g++) begin : g_drv
    spg_drive_model u_drv (.i_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_fmt(CTRL[g][1:0]),
      .i_a(o_step_first[g] ^ CTRL[g][3]), .i_b(o_step_second[g] ^ CTRL[g][4]),
      .o_pos(pos[g]));
  end
  ////////////////////////////////////////////////////////////
  task automatic wb(input logic we, input logic [8:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    @(posedge i_sys_clk);
    while (o_wb_ack !== 1'b1) @(posedge i_sys_clk);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask : wb
  function automatic logic [8:0] ca(input int c, input int w);
    return 9'(c * 64 + w * 4);
  endfunction : ca
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  always @(posedge i_sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      num_errors++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      wb(1'b0, RA[k], 32'h0);
      chk(q, RV[k]);
    end
    $display("test reset values done");
    for (int c = 0; c < 6; c++) begin
      wb(1'b1, ca(c, 5), 32'h200);
      for (int w = 6; w < 9; w++) wb(1'b1, ca(c, w), 32'h14);
      wb(1'b1, ca(c, 3), MAXV[c]);
      if (c == 4) wb(1'b1, ca(c, 4), 32'hFFFF0000);
      wb(1'b1, ca(c, 2), VEL[c]);
      wb(1'b1, ca(c, 0), {26'h0, CTRL[c] & 6'h1F});
    end
    chk(32'(o_step_first[3]), 32'h1);
    chk(32'(o_step_second[4]), 32'h1);
    for (int c = 0; c < 6; c++) wb(1'b1, ca(c, 0), {26'h0, CTRL[c]});
    repeat (1000) @(posedge i_sys_clk);
    for (int c = 0; c < 6; c++) begin
      wb(1'b1, ca(c, 2), 32'h0);
      wb(1'b1, ca(c, 4), 32'h0);
    end
    repeat (60) @(posedge i_sys_clk);
    for (int c = 0; c < 6; c++) begin
      wb(1'b0, ca(c, 9), 32'h0);
      chk(q, pos[c]);
      wb(1'b0, ca(c, 10), 32'h0);
      chk(q, pos[c] << 7);
    end
    chk(pos[5], 32'h0);
    chk(32'(pos[0][31] && pos[1][31] && pos[2][31]), 32'h1);
    chk(32'($signed(pos[3]) > 7 && $signed(pos[3]) < 12), 32'h1);
    chk(32'($signed(pos[4]) > 2 && $signed(pos[4]) < 8), 32'h1);
    $display("test channel motion done");
    old = pos[0];
    wb(1'b1, ca(0, 1), 32'h00640000);
    wb(1'b1, ca(0, 0), 32'h20);
    repeat (400) @(posedge i_sys_clk);
    chk(32'($signed(pos[0]) > $signed(old) + 20), 32'h1);
    $display("test position loop done");
    wb(1'b1, 9'h180, 32'h1);
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_power_en), 32'h1);
    i_power_fault <= 1'b1;
    repeat (8) @(posedge i_sys_clk);
    wb(1'b0, 9'h188, 32'h0);
    chk(q, 32'h1);
    i_power_fault <= 1'b0;
    repeat (8) @(posedge i_sys_clk);
    chk(32'(o_power_en), 32'h1);
    wb(1'b1, 9'h184, 32'h32);
    wb(1'b1, 9'h180, 32'h3);
    repeat (70) @(posedge i_sys_clk);
    wb(1'b0, 9'h188, 32'h0);
    chk(q, 32'h2);
    wb(1'b1, 9'h18C, 32'h0);
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_power_en), 32'h1);
    $display("test power enable done");
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    wb(1'b0, 9'h180, 32'h0);
    chk(q, 32'h0);
    chk(32'({o_step_first, o_power_en}), 32'h0);
    $display("test second reset done");
    end_sim();
  end
endmodule : tb_top
bind spg_top spg_asserts u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack),
  .i_power_fault(i_power_fault), .o_step_first(o_step_first),
  .o_step_second(o_step_second), .o_power_en(o_power_en));
